/* logic/rcfg_defs.vh */
// Constants for the rail configuration register bank and its serial port
`ifndef RCFG_DEFS_VH
`define RCFG_DEFS_VH
`define RCFG_DEV_ADDR 7'h3E
`define RCFG_OFS_POS 8'h00
`define RCFG_OFS_NEG 8'h01
`define RCFG_OFS_OPT 8'h03
`define RCFG_OFS_CTL 8'hFF
`define RCFG_CODE_MAX 5'h14
`define RCFG_OPT_CLASS 6
`define RCFG_OPT_JOINT 2
`define RCFG_OPT_PDIS 1
`define RCFG_OPT_NDIS 0
`define RCFG_CTL_COMMIT 7
`define RCFG_CTL_VIEW 0
`define RCFG_OPT_MASK 8'h47
`define RCFG_POS_RST 5'h0E
`define RCFG_NEG_RST 5'h0E
`define RCFG_OPT_RST 8'h03
`define RCFG_CLK_HZ 10000000
`define RCFG_COMMIT_MS 100
`define RCFG_COMMIT_CYC (`RCFG_CLK_HZ / 1000 * `RCFG_COMMIT_MS)
`define RCFG_LOAD_US 20
`define RCFG_LOAD_CYC (`RCFG_CLK_HZ / 1000000 * `RCFG_LOAD_US - 1)
`define RCFG_LOAD_LAST 5'h0F
`endif

/* logic/rcfg_regs.v */
// Rail configuration register bank with two-wire slave port and store
`timescale 1ns/10ps
`include "rcfg_defs.vh"
// Summary of operation
// R1: Answer only to seven-bit address 3E; last address bit gives direction.
// R2: Direction 0 means master writes; direction 1 means device returns bytes.
// R3: Same protocol at 100 kbps and 400 kbps.
// R4: Start is data falling with clock high; stop is data rising.
// R5: Master makes all clocks and conditions; device never drives clock.
// R6: Eight data bits then one acknowledge bit, repeated freely.
// R7: Receiver acknowledges: device on writes, master on reads.
// R8: After stop, bus is free; wait for start plus own address.
// R9: Non-volatile store and live store share the same addresses.
// R10: At power-up copy stored values into live registers within 20 us.
// R11: Master writes registers 0x00 to 0x03 before setting commit.
// R12: Commit bit starts 100 ms copy of registers into store.
// R13: Master should stay silent during the commit interval.
// R14: Commit bit clears itself when the interval ends.
// R15: Rail codes are five bits, 00h to 14h, 4.0 V plus 0.1 V steps.
// R16: Register 0x03: class bit 6, joint bit 2, drains bits 1 and 0.
// R17: Control at 0xFF: commit bit 7, store view bit 0, rest reserved.
// R18: Reserved bits ignore writes and read as zero here.
// R19: Reads of undefined addresses return 0x00.
// R20: Joint switching: either enable turns both rails on.
// R21: First write byte selects register, next bytes write it.
// R22: Transfers to another address get no acknowledge and are ignored.
module rcfg_regs #(
  parameter COMMIT_CYC = `RCFG_COMMIT_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Two-wire bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // Rail enable pins
  input wire pos_rail_on_i,
  input wire neg_rail_on_i,
  // Settings towards the analog section
  output wire [4:0] positive_rail_code_o,
  output wire [4:0] negative_rail_code_o,
  output wire load_class_select_o,
  output wire pos_rail_drain_en_o,
  output wire neg_rail_drain_en_o,
  output reg pos_rail_run_o,
  output reg neg_rail_run_o,
  output wire load_done_o,
  output wire commit_busy_o
);
  // ==========================================================
  // Pin synchronisers and edge detection
  // ==========================================================
  reg [1:0] scl_sync_reg, sda_sync_reg, enp_sync_reg, enn_sync_reg;
  reg scl_last_reg, sda_last_reg;
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_last_reg; // [R3]
  wire scl_fall = ~scl_s & scl_last_reg;
  wire start_det = scl_s & scl_last_reg & ~sda_s & sda_last_reg; // [R4]
  wire stop_det = scl_s & scl_last_reg & sda_s & ~sda_last_reg; // [R4]

  // Two flops per pin; only the second stage is looked at
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      enp_sync_reg <= 2'b00;
      enn_sync_reg <= 2'b00;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      enp_sync_reg <= {enp_sync_reg[0], pos_rail_on_i};
      enn_sync_reg <= {enn_sync_reg[0], neg_rail_on_i};
      scl_last_reg <= scl_s;
      sda_last_reg <= sda_s;
    end
  end

  // ==========================================================
  // Live store, power-up store and control
  // ==========================================================
  reg [4:0] pos_live_reg, neg_live_reg, pos_nv_reg, neg_nv_reg;
  reg [7:0] opt_live_reg, opt_nv_reg;
  reg commit_reg, view_reg, loaded_reg;
  reg [4:0] load_cnt_reg;
  reg [31:0] commit_cnt_reg;
  reg wr_stb;
  reg [7:0] wr_addr, wr_data;

  assign positive_rail_code_o = pos_live_reg; // [R15]
  assign negative_rail_code_o = neg_live_reg; // [R15]
  assign load_class_select_o = opt_live_reg[`RCFG_OPT_CLASS];
  assign pos_rail_drain_en_o = opt_live_reg[`RCFG_OPT_PDIS];
  assign neg_rail_drain_en_o = opt_live_reg[`RCFG_OPT_NDIS];
  assign load_done_o = loaded_reg;
  assign commit_busy_o = commit_reg;

  // Non-volatile cells hold defaults; only a commit changes them
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_nv_reg <= `RCFG_POS_RST;
      neg_nv_reg <= `RCFG_NEG_RST;
      opt_nv_reg <= `RCFG_OPT_RST;
    end else if (commit_reg && commit_cnt_reg == 32'd0) begin
      pos_nv_reg <= pos_live_reg; // [R12]
      neg_nv_reg <= neg_live_reg;
      opt_nv_reg <= opt_live_reg;
    end
  end

  // Power-up copy, then bus writes and commit timing
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_live_reg <= 5'h00;
      neg_live_reg <= 5'h00;
      opt_live_reg <= 8'h00;
      loaded_reg <= 1'b0;
      load_cnt_reg <= 5'h00;
      commit_reg <= 1'b0;
      view_reg <= 1'b0;
      commit_cnt_reg <= 32'h0000_0000;
    end else if (!loaded_reg) begin
      // Copy happens at once; hold off the bus well inside 20 us
      pos_live_reg <= pos_nv_reg; // [R10] [R9]
      neg_live_reg <= neg_nv_reg;
      opt_live_reg <= opt_nv_reg;
      load_cnt_reg <= load_cnt_reg + 5'h01;
      if (load_cnt_reg == `RCFG_LOAD_LAST)
        loaded_reg <= 1'b1; // [R10]
    end else begin
      if (commit_reg) begin
        if (commit_cnt_reg == 32'd0)
          commit_reg <= 1'b0; // [R14]
        else
          commit_cnt_reg <= commit_cnt_reg - 32'd1; // [R12]
      end
      // Writes during commit are dropped to keep the cells consistent
      if (wr_stb && !commit_reg) begin
        case (wr_addr)
          `RCFG_OFS_POS: if (wr_data[4:0] <= `RCFG_CODE_MAX)
            pos_live_reg <= wr_data[4:0]; // [R15]
          `RCFG_OFS_NEG: if (wr_data[4:0] <= `RCFG_CODE_MAX)
            neg_live_reg <= wr_data[4:0]; // [R15]
          `RCFG_OFS_OPT:
            opt_live_reg <= wr_data & `RCFG_OPT_MASK; // [R16] [R18]
          `RCFG_OFS_CTL: begin
            view_reg <= wr_data[`RCFG_CTL_VIEW]; // [R17]
            if (wr_data[`RCFG_CTL_COMMIT]) begin
              commit_reg <= 1'b1; // [R12]
              commit_cnt_reg <= COMMIT_CYC - 1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Read mux; view bit picks live or stored copy
  reg [7:0] rd_data;
  always @* begin
    case (wr_addr)
      `RCFG_OFS_POS: rd_data = {3'b000, view_reg ? pos_nv_reg : pos_live_reg};
      `RCFG_OFS_NEG: rd_data = {3'b000, view_reg ? neg_nv_reg : neg_live_reg};
      `RCFG_OFS_OPT: rd_data = view_reg ? opt_nv_reg : opt_live_reg; // [R9]
      `RCFG_OFS_CTL: rd_data = {commit_reg, 6'b00_0000, view_reg}; // [R17]
      default: rd_data = 8'h00; // [R19]
    endcase
  end

  // Rail gating; joint mode ORs the two enables
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_rail_run_o <= 1'b0;
      neg_rail_run_o <= 1'b0;
    end else if (opt_live_reg[`RCFG_OPT_JOINT]) begin
      pos_rail_run_o <= enp_sync_reg[1] | enn_sync_reg[1]; // [R20]
      neg_rail_run_o <= enp_sync_reg[1] | enn_sync_reg[1]; // [R20]
    end else begin
      pos_rail_run_o <= enp_sync_reg[1];
      neg_rail_run_o <= enn_sync_reg[1];
    end
  end

  // ==========================================================
  // Serial slave state machine
  // ==========================================================
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_WBYTE = 3'd3;
  localparam ST_RBYTE = 3'd4;
  localparam ST_RACK = 3'd5;

  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg rw_reg, have_reg_reg, ack_drv_reg, sda_drv_reg;
  reg [7:0] ptr_reg;

  // Open drain: only low is ever driven; clock pin is input only
  assign sda_o = 1'b0; // [R5]
  assign sda_oe_o = ack_drv_reg | sda_drv_reg; // [R7]

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      have_reg_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (!loaded_reg || stop_det) begin
        state_reg <= ST_IDLE; // [R8]
        ack_drv_reg <= 1'b0;
        sda_drv_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= ST_ADDR; // [R4]
        bit_cnt_reg <= 4'h0;
        have_reg_reg <= 1'b0;
        ack_drv_reg <= 1'b0;
        sda_drv_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: ;
          ST_ADDR, ST_WBYTE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s}; // [R6]
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `RCFG_DEV_ADDR) begin // [R1]
                  rw_reg <= shift_reg[0]; // [R2]
                  ack_drv_reg <= 1'b1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE; // [R22]
                end
              end else begin
                ack_drv_reg <= 1'b1; // [R7]
                state_reg <= ST_ACK;
                if (!have_reg_reg) begin
                  ptr_reg <= shift_reg; // [R21]
                  wr_addr <= shift_reg;
                  have_reg_reg <= 1'b1;
                end else begin
                  wr_stb <= 1'b1; // [R21]
                  wr_addr <= ptr_reg;
                  wr_data <= shift_reg;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              ack_drv_reg <= 1'b0;
              if (rw_reg) begin
                // Read pointer stays put; repeated reads return same byte
                wr_addr <= ptr_reg;
                state_reg <= ST_RBYTE; // [R2]
                bit_cnt_reg <= 4'h0;
              end else begin
                state_reg <= ST_WBYTE;
              end
            end
          end
          ST_RBYTE: begin
            // Drive low for zero bits; data changes only while clock low
            if (bit_cnt_reg == 4'h0 && !scl_s && !sda_drv_reg &&
                !scl_rise) begin
              shift_reg <= rd_data;
              sda_drv_reg <= ~rd_data[7];
              bit_cnt_reg <= 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                sda_drv_reg <= 1'b0;
                state_reg <= ST_RACK; // [R7]
              end else begin
                sda_drv_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= sda_s ? ST_IDLE : ST_RBYTE; // [R7]
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // rcfg_regs

/* tb/rcfg_master.sv */
// Two-wire bus master model with start, stop and byte tasks
`timescale 1ns/10ps
module rcfg_master (
  // Bus pins; data pulled low while sda_low_o is high
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // ====================
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Start: data falls while clock high
  task automatic start();
    sda_low_o = 1'b1;
    #400 scl_o = 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    #100 sda_low_o = 1'b1;
    #400 scl_o = 1'b1;
    #400 sda_low_o = 1'b0;
    #400;
  endtask
  // One bit; long low phase leaves room for the device to answer
  task automatic xbit(input logic b, output logic r);
    #100 sda_low_o = !b;
    #400 scl_o = 1'b1;
    #250 r = sda_i;
    #50 scl_o = 0;
  endtask
  // Eight bits MSB first, then a released ack bit
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
                       output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(1'b1, r);
    k = !r;
  endtask
endmodule // rcfg_master

/* tb/rcfg_regs_properties.sv */
// Assertions on the register bank ports
`timescale 1ns/10ps
module rcfg_regs_properties #(
  parameter COMMIT_CYC = 50
) (
  // Watched ports
  input wire clk_i,
  input wire rstn_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire pos_rail_on_i,
  input wire neg_rail_on_i,
  input wire [4:0] positive_rail_code_o,
  input wire [4:0] negative_rail_code_o,
  input wire pos_rail_run_o,
  input wire neg_rail_run_o,
  input wire load_done_o,
  input wire commit_busy_o
);
  // ====================
  // Commit length counter
  logic [31:0] busy_cnt;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) busy_cnt <= 32'h0000_0000;
    else if (commit_busy_o) busy_cnt <= busy_cnt + 32'h0000_0001;
    else busy_cnt <= 32'h0000_0000;
  end
  // Small slack covers the pin synchronisers
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_open_drain; sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin driven high");
  property p_oe_scl_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data moved while clock high");
  property p_code_max;
    positive_rail_code_o <= 5'h14 && negative_rail_code_o <= 5'h14;
  endproperty
  a_code_max: assert property (p_code_max)
    else $error("rail code above limit");
  property p_quiet_load; !load_done_o |-> !sda_oe_o; endproperty
  a_quiet_load: assert property (p_quiet_load)
    else $error("bus answered before load");
  property p_load_time; $rose(rstn_i) |-> ##[1:200] load_done_o; endproperty
  a_load_time: assert property (p_load_time)
    else $error("store load too slow");
  property p_load_hold; load_done_o |=> load_done_o; endproperty
  a_load_hold: assert property (p_load_hold)
    else $error("load flag dropped");
  property p_commit_len;
    $fell(commit_busy_o) |-> busy_cnt + 4 >= COMMIT_CYC
      && busy_cnt <= COMMIT_CYC + 4;
  endproperty
  a_commit_len: assert property (p_commit_len)
    else $error("commit interval wrong length");
  property p_pos_run; pos_rail_on_i [*6] |-> pos_rail_run_o; endproperty
  a_pos_run: assert property (p_pos_run)
    else $error("positive rail not running");
  property p_neg_run; neg_rail_on_i [*6] |-> neg_rail_run_o; endproperty
  a_neg_run: assert property (p_neg_run)
    else $error("negative rail not running");
  property p_all_off;
    (!pos_rail_on_i && !neg_rail_on_i) [*6] |->
      !pos_rail_run_o && !neg_rail_run_o;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("rail running with enables low");
endmodule // rcfg_regs_properties
bind rcfg_regs rcfg_regs_properties #(.COMMIT_CYC(COMMIT_CYC))
  rcfg_regs_properties_i (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pos_rail_on_i(pos_rail_on_i),
  .neg_rail_on_i(neg_rail_on_i), .positive_rail_code_o(positive_rail_code_o),
  .negative_rail_code_o(negative_rail_code_o),
  .pos_rail_run_o(pos_rail_run_o), .neg_rail_run_o(neg_rail_run_o),
  .load_done_o(load_done_o), .commit_busy_o(commit_busy_o));

/* tb/rcfg_regs_test.sv */
// Self-checking bench for the rail configuration register bank
`timescale 1ns/10ps
module rcfg_regs_test;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pon = 1'b0;
  logic non = 1'b0;
  wire scl, mlow, sda, sdo, soe, cls, pd, nd, pr, nr, ld, busy;
  wire [4:0] pc, nc;
  int fails = 0;
  int tests_run = 0;
  // ====================
  // Open-drain data line with pull-up
  assign sda = !(mlow || (soe && !sdo));
  always #50 clk_i = ~clk_i;
  rcfg_master rcfg_master_i (.scl_o(scl), .sda_low_o(mlow), .sda_i(sda));
  rcfg_regs #(.COMMIT_CYC(200)) rcfg_regs_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_o(soe), .pos_rail_on_i(pon), .neg_rail_on_i(non),
    .positive_rail_code_o(pc), .negative_rail_code_o(nc),
    .load_class_select_o(cls), .pos_rail_drain_en_o(pd),
    .neg_rail_drain_en_o(nd), .pos_rail_run_o(pr), .neg_rail_run_o(nr),
    .load_done_o(ld), .commit_busy_o(busy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write one register; only the own address is acknowledged
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [6:0] dev = 7'h3E);
    logic [7:0] q;
    logic k;
    rcfg_master_i.start();
    rcfg_master_i.xbyte({dev, 1'b0}, q, k);
    chk(8'(k), 8'(dev == 7'h3E));
    if (k) begin
      rcfg_master_i.xbyte(a, q, k);
      rcfg_master_i.xbyte(d, q, k);
      chk(8'(k), 8'h01);
    end
    rcfg_master_i.stop();
  endtask
  // Set pointer, then read one byte and end with no ack
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic k;
    rcfg_master_i.start();
    rcfg_master_i.xbyte(8'h7C, q, k);
    rcfg_master_i.xbyte(a, q, k);
    rcfg_master_i.stop();
    rcfg_master_i.start();
    rcfg_master_i.xbyte(8'h7D, q, k);
    chk(8'(k), 8'h01);
    rcfg_master_i.xbyte(8'hFF, q, k);
    rcfg_master_i.stop();
    chk(q, exp);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #5 rstn_i = 1'b1;
    repeat (200) @(posedge clk_i);
    // Keep every later pin change clear of the sampling edge
    #5 chk({2'b00, ld, pc}, 8'h2E);
    rd(8'h00, 8'h0E);
    rd(8'h01, 8'h0E);
    rd(8'h03, 8'h03);
    rd(8'h02, 8'h00);
    rd(8'hFF, 8'h00);
    $display("test power-up values ends");
    wr(8'h00, 8'h05, 7'h3F);
    wr(8'h00, 8'h14);
    wr(8'h00, 8'h15);
    rd(8'h00, 8'h14);
    wr(8'h01, 8'h00);
    chk({3'b000, nc}, 8'h00);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h47);
    chk({5'h00, cls, pd, nd}, 8'h07);
    wr(8'hFF, 8'h7E);
    rd(8'hFF, 8'h00);
    $display("test register access ends");
    @(posedge clk_i) #5 pon = 1'b1;
    repeat (10) @(posedge clk_i);
    #5 chk({6'h00, pr, nr}, 8'h03);
    // Joint mode: the negative enable alone must run both rails
    @(posedge clk_i) #5 {pon, non} = 2'b01;
    repeat (10) @(posedge clk_i);
    #5 chk({6'h00, pr, nr}, 8'h03);
    @(posedge clk_i) #5 {pon, non} = 2'b10;
    repeat (10) @(posedge clk_i);
    #5 wr(8'h03, 8'h40);
    chk({6'h00, pr, nr}, 8'h02);
    @(posedge clk_i) #5 pon = 1'b0;
    repeat (10) @(posedge clk_i);
    #5 chk({6'h00, pr, nr}, 8'h00);
    $display("test rail switching ends");
    wr(8'h00, 8'h0A);
    wr(8'h01, 8'h0B);
    wr(8'h03, 8'h44);
    wr(8'hFF, 8'h80);
    chk(8'(busy), 8'h01);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk_i);
    #5 chk(8'(busy), 8'h00);
    rd(8'hFF, 8'h00);
    wr(8'h00, 8'h03);
    wr(8'hFF, 8'h01);
    rd(8'h00, 8'h0A);
    rd(8'hFF, 8'h01);
    wr(8'hFF, 8'h00);
    rd(8'h00, 8'h03);
    $display("test store commit ends");
    print_verdict();
  end
  // Watchdog: full run is under 1 ms, so 8 ms means a hang
  initial begin
    #8ms;
    fails++;
    print_verdict();
  end
endmodule // rcfg_regs_test
